// ===== rtc_alarm_irq_ctrl_test.sv
`timescale 1ns/100ps
module rtc_alarm_irq_ctrl_test;
   logic       clk_in = 1'h0, rst_n_in = 1'h0, nobat_n = 1'h0, wr = 1'h0, rd = 1'h0;
   logic       fclr = 1'h0, wd = 1'h0, ce = 1'h1, flag;
   logic [7:0] addr = 8'h00, wdata = 8'h00, ss = 8'hA5, hr = 8'hB7, rdata;
   logic [5:0] sec = 6'h3B, mn = 6'h3B, hi, lo;
   logic [3:0] cen = 4'h0, pins = 4'h0;
   int         n_errors = 0, num_checks = 0;
   always #20 clk_in = ~clk_in;
   rtcai_alarm_irq_ctrl rtcai_alarm_irq_ctrl_i
   (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .nobat_rst_n_in(nobat_n), .ce_in(ce),
      .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rd_in(rd),
      .subsecond_counter_in(ss), .second_counter_in(sec), .minute_counter_in(mn),
      .hour_counter_in(hr), .compare_enable_in(cen), .flag_clear_in(fclr),
      .watchdog_pending_in(wd), .pin_pending_in(pins), .sfr_rdata_out(rdata),
      .clock_alarm_flag_out(flag), .irq_high_out(hi), .irq_low_out(lo)
   );
   task chk(input string nm, input logic [7:0] seen, exp);
      num_checks++;
      n_errors += int'(seen !== exp);
      if (seen !== exp)
         $display("Error %s expected %h seen %h", nm, exp, seen);
   endtask
   task stop_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task acc(input logic w, input logic [7:0] a, d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      @(posedge clk_in);
      wr    <= 1'h0;
      rd    <= 1'h0;
      @(negedge clk_in);
      if (!w)
         chk("read data", rdata, d);
   endtask
   task t_regs;
      acc(1'h1, 8'hE8, 8'hFF);
      acc(1'h1, 8'hF8, 8'hFF);
      acc(1'h0, 8'hF8, 8'h3F);
      acc(1'h1, 8'hF2, 8'hA5);
      acc(1'h1, 8'hF3, 8'h3B);
      acc(1'h1, 8'hF4, 8'h3B);
      acc(1'h1, 8'hF5, 8'h17);
   endtask
   task t_keep;
      @(posedge clk_in);
      rst_n_in <= 1'h0;
      @(posedge clk_in);
      rst_n_in <= 1'h1;
      acc(1'h0, 8'hE8, 8'h00);
      acc(1'h0, 8'hF2, 8'hA5);
      acc(1'h0, 8'hF3, 8'h3B);
      acc(1'h0, 8'hF4, 8'h3B);
      acc(1'h0, 8'hF5, 8'h17);
   endtask
   task t_route;
      acc(1'h1, 8'hE8, 8'h1F);
      acc(1'h1, 8'hF8, 8'h0A);
      @(posedge clk_in);
      wd   <= 1'h1;
      pins <= 4'hF;
      cyc(2);
      chk("high req", {2'h0, hi}, 8'h0A);
      chk("low req", {2'h0, lo}, 8'h15);
   endtask
   task t_alarm;
      acc(1'h1, 8'hE8, 8'h20);
      @(posedge clk_in);
      cen <= 4'hF;
      cyc(2);
      chk("flag", {7'h00, flag}, 8'h01);
      chk("alarm req", {2'h0, lo}, 8'h20);
      @(posedge clk_in);
      fclr <= 1'h1;
      @(posedge clk_in);
      fclr <= 1'h0;
      cyc(0);
      chk("cleared", {7'h00, flag}, 8'h00);
      @(posedge clk_in);
      cen <= 4'h1;
      ss  <= 8'h10;
      cyc(2);
      chk("repeat", {7'h00, flag}, 8'h01);
      @(posedge clk_in);
      fclr <= 1'h1;
      ss   <= 8'h20;
      @(posedge clk_in);
      fclr <= 1'h0;
      cyc(0);
      chk("set over clear", {7'h00, flag}, 8'h01);
   endtask
   task t_freeze;
      @(posedge clk_in);
      ce  <= 1'h0;
      cen <= 4'h0;
      acc(1'h1, 8'hE8, 8'h00);
      chk("frozen flag", {7'h00, flag}, 8'h01);
      chk("frozen req", {2'h0, lo}, 8'h20);
      @(posedge clk_in);
      ce <= 1'h1;
      acc(1'h0, 8'hE8, 8'h20);
      chk("enables off", {7'h00, flag}, 8'h00);
      @(posedge clk_in);
      nobat_n <= 1'h0;
      @(posedge clk_in);
      nobat_n <= 1'h1;
      acc(1'h0, 8'hF3, 8'h00);
      acc(1'h0, 8'hF5, 8'h00);
   endtask
   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'h1;
      nobat_n  <= 1'h1;
      t_regs;
      t_keep;
      t_route;
      t_alarm;
      t_freeze;
      stop_test;
   end
endmodule

// ===== rtcai_alarm_irq_ctrl.v
// How it works
// - enable bit 5 gates clock alarm requests; reads 0 on clockless variants.
// - enable bit 4 gates the watchdog request.
// - enable bits 3..0 gate pin interrupts 5, 4, 3, 2.
// - enable bits 7..6 reserved; they read as zero here.
// - subsecond alarm byte matches subsecond counter only when its compare enable set.
// - subsecond alarm holds through all resets but the no-battery reset.
// - seconds alarm in bits 5..0, gated by its compare enable; bits 7..6 read 0.
// - minutes alarm in bits 5..0, gated by its compare enable; bits 7..6 read 0.
// - seconds and minutes alarms survive all resets but no-battery; upper bits stay 0.
// - hours alarm in bits 4..0, gated by its compare enable; bits 7..5 read 0.
// - weekday bits of the hour counter never take part in comparison.
// - hours alarm survives all resets but no-battery; bits 7..5 stay 0.
// - priority bits 7..6 always read 0.
// - priority bit 5 ranks clock alarm; reads 0 on clockless variants.
// - priority bit 4 ranks the watchdog interrupt.
// - priority bits 3..0 rank pin interrupts 5, 4, 3, 2.
// - alarm flag sets when all enabled fields match; no enables clears it.
// - disabled fields are ignored, giving repeated alarms as they advance.
`timescale 1ns/100ps
`include "rtcai_defines.vh"

module rtcai_alarm_irq_ctrl
#(
   parameter HAS_CLOCK = 1
)
(
   input  wire       clk_in,
   input  wire       rst_n_in,
   input  wire       nobat_rst_n_in,
   input  wire       ce_in,
   input  wire [7:0] sfr_addr_in,
   input  wire       sfr_wr_in,
   input  wire [7:0] sfr_wdata_in,
   input  wire       sfr_rd_in,
   input  wire [7:0] subsecond_counter_in,
   input  wire [5:0] second_counter_in,
   input  wire [5:0] minute_counter_in,
   input  wire [7:0] hour_counter_in,
   input  wire [3:0] compare_enable_in,
   input  wire       flag_clear_in,
   input  wire       watchdog_pending_in,
   input  wire [3:0] pin_pending_in,
   output wire [7:0] sfr_rdata_out,
   output wire       clock_alarm_flag_out,
   output wire [5:0] irq_high_out,
   output wire [5:0] irq_low_out
);

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   function addr_hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   wire wr_enable   = ce_in & sfr_wr_in & addr_hit(sfr_addr_in, `RTCAI_OFF_EXT_IRQ_ENABLE);
   wire wr_priority = ce_in & sfr_wr_in & addr_hit(sfr_addr_in, `RTCAI_OFF_EXT_IRQ_PRIORITY);
   wire wr_subsec   = ce_in & sfr_wr_in & addr_hit(sfr_addr_in, `RTCAI_OFF_ALARM_SUBSECOND);
   wire wr_sec      = ce_in & sfr_wr_in & addr_hit(sfr_addr_in, `RTCAI_OFF_ALARM_SECOND);
   wire wr_min      = ce_in & sfr_wr_in & addr_hit(sfr_addr_in, `RTCAI_OFF_ALARM_MINUTE);
   wire wr_hour     = ce_in & sfr_wr_in & addr_hit(sfr_addr_in, `RTCAI_OFF_ALARM_HOUR);

   // ----------------------------------------------------------------------
   // enable and priority registers
   // ----------------------------------------------------------------------
   reg  [5:0] irq_enable_q;
   reg  [5:0] irq_level_q;
   wire [5:0] variant_mask;

   // a clockless part has no alarm source, so its bits are hard zero
   assign variant_mask = (HAS_CLOCK != 0) ? 6'h3F : 6'h1F;

   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         irq_enable_q <= `RTCAI_RST_IRQ_BITS;
         irq_level_q  <= `RTCAI_RST_IRQ_BITS;
      end
      else
      begin
         if (wr_enable)
            irq_enable_q <= sfr_wdata_in[5:0] & variant_mask;
         if (wr_priority)
            irq_level_q <= sfr_wdata_in[5:0] & variant_mask;
      end
   end

   // ----------------------------------------------------------------------
   // alarm registers
   // ----------------------------------------------------------------------
   // only the no-battery reset touches them; it clears to zero so that
   // simulation never sees unknowns even though software may not rely on it
   reg [7:0] alarm_subsecond_q;
   reg [5:0] alarm_second_q;
   reg [5:0] alarm_minute_q;
   reg [4:0] alarm_hour_q;

   always @(posedge clk_in)
   begin
      if (!nobat_rst_n_in)
      begin
         alarm_subsecond_q <= `RTCAI_RST_ALARM_SUBSEC;
         alarm_second_q    <= `RTCAI_RST_ALARM_SEC;
         alarm_minute_q    <= `RTCAI_RST_ALARM_MIN;
         alarm_hour_q      <= `RTCAI_RST_ALARM_HOUR;
      end
      else
      begin
         // range limits are left to software; values are stored as written
         if (wr_subsec)
            alarm_subsecond_q <= sfr_wdata_in;
         if (wr_sec)
            alarm_second_q <= sfr_wdata_in[5:0];
         if (wr_min)
            alarm_minute_q <= sfr_wdata_in[5:0];
         if (wr_hour)
            alarm_hour_q <= sfr_wdata_in[4:0];
      end
   end

   // ----------------------------------------------------------------------
   // alarm comparison
   // ----------------------------------------------------------------------
   wire eq_subsec = (alarm_subsecond_q == subsecond_counter_in);
   wire eq_sec    = (alarm_second_q == second_counter_in);
   wire eq_min    = (alarm_minute_q == minute_counter_in);
   // weekday bits in the top of the hour counter are never looked at
   wire eq_hour   = (alarm_hour_q == hour_counter_in[4:0]);

   wire any_compare = |compare_enable_in;
   wire match_now   = any_compare
                      & (eq_subsec | ~compare_enable_in[`RTCAI_CE_SUBSEC])
                      & (eq_sec    | ~compare_enable_in[`RTCAI_CE_SEC])
                      & (eq_min    | ~compare_enable_in[`RTCAI_CE_MIN])
                      & (eq_hour   | ~compare_enable_in[`RTCAI_CE_HOUR]);

   // a new alarm is raised each time the time changes while still matching,
   // which gives the repeat-per-tick behaviour of ignored fields
   reg [7:0] prev_subsec_q;
   reg [5:0] prev_sec_q;
   reg [5:0] prev_min_q;
   reg [4:0] prev_hour_q;
   reg       prev_match_q;

   wire time_moved = (prev_subsec_q != subsecond_counter_in)
                   | (prev_sec_q != second_counter_in)
                   | (prev_min_q != minute_counter_in)
                   | (prev_hour_q != hour_counter_in[4:0]);
   wire alarm_event = match_now & (time_moved | ~prev_match_q);

   always @(posedge clk_in)
   begin
      if (!nobat_rst_n_in)
      begin
         prev_subsec_q <= `RTCAI_RST_BYTE;
         prev_sec_q    <= `RTCAI_RST_ALARM_SEC;
         prev_min_q    <= `RTCAI_RST_ALARM_MIN;
         prev_hour_q   <= `RTCAI_RST_ALARM_HOUR;
         prev_match_q  <= 1'b0;
      end
      else if (ce_in)
      begin
         prev_subsec_q <= subsecond_counter_in;
         prev_sec_q    <= second_counter_in;
         prev_min_q    <= minute_counter_in;
         prev_hour_q   <= hour_counter_in[4:0];
         prev_match_q  <= match_now;
      end
   end

   // ----------------------------------------------------------------------
   // alarm flag
   // ----------------------------------------------------------------------
   reg clock_alarm_flag_q;
   reg clock_alarm_flag_d;

   always @*
   begin
      clock_alarm_flag_d = clock_alarm_flag_q;
      if (flag_clear_in)
         clock_alarm_flag_d = 1'b0;
      if (alarm_event)
         clock_alarm_flag_d = 1'b1;
      if (!any_compare)
         clock_alarm_flag_d = 1'b0;
   end

   always @(posedge clk_in)
   begin
      if (!nobat_rst_n_in)
         clock_alarm_flag_q <= 1'b0;
      else if (ce_in)
         clock_alarm_flag_q <= clock_alarm_flag_d;
   end

   assign clock_alarm_flag_out = clock_alarm_flag_q;

   // ----------------------------------------------------------------------
   // request steering
   // ----------------------------------------------------------------------
   wire [5:0] pending;
   reg  [5:0] irq_high_q;
   reg  [5:0] irq_low_q;

   assign pending = {clock_alarm_flag_q & (HAS_CLOCK != 0), watchdog_pending_in,
                     pin_pending_in};

   genvar g;
   generate
      for (g = 0; g < `RTCAI_SRC_COUNT; g = g + 1)
      begin : g_src
         always @(posedge clk_in)
         begin
            if (!rst_n_in)
            begin
               irq_high_q[g] <= 1'b0;
               irq_low_q[g]  <= 1'b0;
            end
            else if (ce_in)
            begin
               irq_high_q[g] <= pending[g] & irq_enable_q[g] & irq_level_q[g];
               irq_low_q[g]  <= pending[g] & irq_enable_q[g] & ~irq_level_q[g];
            end
         end
      end
   endgenerate

   assign irq_high_out = irq_high_q;
   assign irq_low_out  = irq_low_q;

   // ----------------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------------
   reg [7:0] rdata_q;
   reg [7:0] rdata_d;

   always @*
   begin
      rdata_d = `RTCAI_RST_BYTE;
      case (sfr_addr_in)
         `RTCAI_OFF_EXT_IRQ_ENABLE:   rdata_d = {2'b00, irq_enable_q};
         `RTCAI_OFF_EXT_IRQ_PRIORITY: rdata_d = {2'b00, irq_level_q};
         `RTCAI_OFF_ALARM_SUBSECOND:  rdata_d = alarm_subsecond_q;
         `RTCAI_OFF_ALARM_SECOND:     rdata_d = {2'b00, alarm_second_q};
         `RTCAI_OFF_ALARM_MINUTE:     rdata_d = {2'b00, alarm_minute_q};
         `RTCAI_OFF_ALARM_HOUR:       rdata_d = {3'b000, alarm_hour_q};
         default:                     rdata_d = `RTCAI_RST_BYTE;
      endcase
   end

   always @(posedge clk_in)
   begin
      if (!rst_n_in)
         rdata_q <= `RTCAI_RST_BYTE;
      else if (ce_in & sfr_rd_in)
         rdata_q <= rdata_d;
   end

   assign sfr_rdata_out = rdata_q;

endmodule

// ===== rtcai_checker.sv
`timescale 1ns/100ps
module rtcai_checker
(
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   input wire logic       nobat_rst_n_in,
   input wire logic       ce_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic       sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic       sfr_rd_in,
   input wire logic [7:0] subsecond_counter_in,
   input wire logic [5:0] second_counter_in,
   input wire logic [5:0] minute_counter_in,
   input wire logic [7:0] hour_counter_in,
   input wire logic [3:0] compare_enable_in,
   input wire logic       flag_clear_in,
   input wire logic       watchdog_pending_in,
   input wire logic [3:0] pin_pending_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic       clock_alarm_flag_out,
   input wire logic [5:0] irq_high_out,
   input wire logic [5:0] irq_low_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // a frozen edge (ce_in low) says nothing about the next request
   wire [5:0] req = irq_high_out | irq_low_out;
   AST_ONE_LEVEL: assert property ((irq_high_out & irq_low_out) == 6'h00)
      else $error("request at both levels");
   AST_PIN: assert property ($past(ce_in) |-> (req[3:0] & ~$past(pin_pending_in)) == 4'h0)
      else $error("pin request without pending");
   AST_ALARM_SRC: assert property (req[5] && $past(ce_in) |-> $past(clock_alarm_flag_out))
      else $error("alarm request without flag");
   AST_OFF: assert property (ce_in && compare_enable_in == 4'h0 |=> !clock_alarm_flag_out)
      else $error("flag kept with compares off");
   AST_FLAG_HOLD: assert property (clock_alarm_flag_out && ce_in && nobat_rst_n_in
      && !flag_clear_in && |compare_enable_in |=> clock_alarm_flag_out) else $error("flag lost");
   AST_RISE: assert property ($rose(clock_alarm_flag_out) |-> |$past(compare_enable_in))
      else $error("flag rose with no compare enabled");
   AST_HOUR_RSV: assert property (sfr_rd_in && ce_in && sfr_addr_in == 8'hF5
      |=> sfr_rdata_out[7:5] == 3'h0) else $error("hour reserved bits set");
   AST_PRIO_RSV: assert property (sfr_rd_in && ce_in && sfr_addr_in == 8'hF8
      |=> sfr_rdata_out[7:6] == 2'h0) else $error("priority reserved bits set");
endmodule
bind rtcai_alarm_irq_ctrl rtcai_checker rtcai_checker_i (.*);

// ===== rtcai_defines.vh
`ifndef RTCAI_DEFINES_VH
`define RTCAI_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets in special function register space
// ----------------------------------------------------------------------
`define RTCAI_OFF_EXT_IRQ_ENABLE   8'hE8
`define RTCAI_OFF_ALARM_SUBSECOND  8'hF2
`define RTCAI_OFF_ALARM_SECOND     8'hF3
`define RTCAI_OFF_ALARM_MINUTE     8'hF4
`define RTCAI_OFF_ALARM_HOUR       8'hF5
`define RTCAI_OFF_EXT_IRQ_PRIORITY 8'hF8

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define RTCAI_BIT_CLOCK_ALARM      5
`define RTCAI_BIT_WATCHDOG         4
`define RTCAI_BIT_PIN5             3
`define RTCAI_BIT_PIN2             0
`define RTCAI_SRC_COUNT            6
`define RTCAI_SUBSEC_W             8
`define RTCAI_SEC_W                6
`define RTCAI_MIN_W                6
`define RTCAI_HOUR_W               5

// compare enable positions inside the 4-bit compare enable input
`define RTCAI_CE_SUBSEC            3
`define RTCAI_CE_SEC               2
`define RTCAI_CE_MIN               1
`define RTCAI_CE_HOUR              0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RTCAI_RST_IRQ_BITS         6'h00
`define RTCAI_RST_BYTE             8'h00
`define RTCAI_RST_ALARM_SUBSEC     8'h00
`define RTCAI_RST_ALARM_SEC        6'h00
`define RTCAI_RST_ALARM_MIN        6'h00
`define RTCAI_RST_ALARM_HOUR       5'h00

`endif
